//--- lps_regs.sv
// Control and status registers of an ambient-light and proximity sensor
// Assumes a byte register port driven by an I2C slave on the same clock
`timescale 1ns/100ps
`include "lps_cfg.svh"
// Summary of operation
// - Power-up flag in status bit 2 sets on power-on or supply-glitch reset.
// - Power-up returns all interrupt threshold settings to their defaults.
// - Power-up flag pulls interrupt low, except on first silicon revision.
// - Power-up flag stays set until host reads the status register.
// - Gain source bit 5 picks factory gains (1) or host trim bytes (0).
// - Mode 000 shuts analog down; digital registers keep contents.
// - Mode 001 stores green minus infrared, or 0 if infrared is not below green; proximity channel idle.
// - Mode 010 green only, 011 infrared only; proximity idle.
// - Mode 100 alternates ambient and proximity, updating both.
// - Mode 101 runs proximity only; ambient not updated.
// - Proximity enable 0 stops proximity compare; its flag stays 0.
// - Proximity enable 1 lets a qualifying event set bit 1 and interrupt.
// - Ambient enable 0 stops ambient compare; its flag stays 0.
// - Ambient enable 1 lets a qualifying event set bit 0 and interrupt.
// - Receive config at 0x02: time in 3:2, gain 1:0, 7:4 read one.
// - Ambient conversion resolves MSB first; longer time gives more bits.
// - Two-bit time field picks integration period and resolution.
// - Codes 00..11 give 100/25/6.25/1.5625 ms with 14/12/10/8 bits.
// - Reading status clears all three flags and releases interrupt.
// - Writing 0 to an interrupt enable clears its flag at once.
module lps_regs #(
    parameter bit FIRST_REVISION = 1'b0,
    parameter int unsigned CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Events from the threshold and persist logic
    input wire logic i_light_event,
    input wire logic i_near_event,
    // Converter results
    input wire logic i_light_done,
    input wire logic [13:0] i_green_data,
    input wire logic [13:0] i_ir_data,
    input wire logic i_near_done,
    input wire logic [7:0] i_near_data,
    // Gain trims in use
    input wire logic [7:0] i_factory_green_gain,
    input wire logic [7:0] i_factory_ir_gain,
    output logic [7:0] o_green_fine_gain,
    output logic [7:0] o_infrared_fine_gain,
    // Analog and channel control
    output logic o_analog_enable,
    output logic o_ambient_channel_run,
    output logic o_near_channel_run,
    output logic [1:0] o_light_src,
    output logic [1:0] o_light_gain_select,
    output logic o_light_compare_en,
    output logic o_near_compare_en,
    output logic o_threshold_reset,
    // Results
    output logic [13:0] o_light_result,
    output logic [3:0] o_light_bits,
    output logic [7:0] o_near_result,
    // Interrupt pin, open drain
    output logic o_int_out,
    output logic o_int_oen
);
    logic [7:0] main_cfg_r;
    logic [7:0] rx_cfg_r;
    logic [7:0] trim_green_r;
    logic [7:0] trim_ir_r;
    logic power_up_flag_r;
    logic light_irq_flag_r;
    logic near_irq_flag_r;
    logic por_pulse_r;
    logic phase_near_r;
    logic conv_start_r;
    logic conv_busy;
    logic conv_done;
    logic [3:0] conv_bits;
    logic [2:0] mode;
    logic status_rd;
    logic main_wr;
    logic light_en_nxt;
    logic near_en_nxt;
    lps_pkg::op_mode_t mode_e;

    assign mode = main_cfg_r[`MODE_MSB:`MODE_LSB];
    assign mode_e = lps_pkg::op_mode_t'(mode);
    assign status_rd = i_reg_rd && (i_reg_addr == `ADDR_IRQ_STATUS);
    assign main_wr = i_reg_wr && (i_reg_addr == `ADDR_MAIN_CFG);
    assign light_en_nxt = main_wr ? i_reg_wdata[`BIT_LIGHT_EN] : main_cfg_r[`BIT_LIGHT_EN];
    assign near_en_nxt = main_wr ? i_reg_wdata[`BIT_NEAR_EN] : main_cfg_r[`BIT_NEAR_EN];

    function automatic logic mode_runs_light(input lps_pkg::op_mode_t m);
        mode_runs_light = (m == lps_pkg::MODE_LIGHT_DIFF) || (m == lps_pkg::MODE_LIGHT_GREEN)
            || (m == lps_pkg::MODE_LIGHT_IR) || (m == lps_pkg::MODE_INTERLEAVE);
    endfunction

    function automatic logic mode_runs_near(input lps_pkg::op_mode_t m);
        mode_runs_near = (m == lps_pkg::MODE_INTERLEAVE) || (m == lps_pkg::MODE_NEAR_ONLY);
    endfunction

    // One-cycle pulse after every reset, power-on or glitch
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            por_pulse_r <= 1'b1;
        end else begin
            por_pulse_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_threshold_reset <= 1'b1;
        end else begin
            o_threshold_reset <= por_pulse_r;
        end
    end

    // Configuration registers; reserved modes stored as written
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            main_cfg_r <= `MAIN_CFG_RESET;
            rx_cfg_r <= `RX_CFG_RESET;
            trim_green_r <= `TRIM_RESET;
            trim_ir_r <= `TRIM_RESET;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                `ADDR_MAIN_CFG: main_cfg_r <= {2'h0, i_reg_wdata[5:0]};
                `ADDR_RX_CFG: rx_cfg_r <= {4'h0, i_reg_wdata[3:0]};
                `ADDR_TRIM_GREEN: trim_green_r <= i_reg_wdata;
                `ADDR_TRIM_IR: trim_ir_r <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Status flags: set wins over the read clear
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            power_up_flag_r <= 1'b1;
        end else if (status_rd) begin
            power_up_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            light_irq_flag_r <= 1'b0;
        end else if (!light_en_nxt) begin
            light_irq_flag_r <= 1'b0;
        end else if (i_light_event) begin
            light_irq_flag_r <= 1'b1;
        end else if (status_rd) begin
            light_irq_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            near_irq_flag_r <= 1'b0;
        end else if (!near_en_nxt) begin
            near_irq_flag_r <= 1'b0;
        end else if (i_near_event) begin
            near_irq_flag_r <= 1'b1;
        end else if (status_rd) begin
            near_irq_flag_r <= 1'b0;
        end
    end

    // Open-drain interrupt: enable low pulls the pin low
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_int_out <= 1'b0;
            o_int_oen <= 1'b1;
        end else begin
            o_int_out <= 1'b0;
            o_int_oen <= !(light_irq_flag_r || near_irq_flag_r
                || (power_up_flag_r && !FIRST_REVISION));
        end
    end

    // Read data
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                `ADDR_IRQ_STATUS: o_reg_rdata <= {5'h00, power_up_flag_r, near_irq_flag_r,
                    light_irq_flag_r};
                `ADDR_MAIN_CFG: o_reg_rdata <= main_cfg_r;
                `ADDR_RX_CFG: o_reg_rdata <= rx_cfg_r | `RX_CFG_FIXED;
                `ADDR_TRIM_GREEN: o_reg_rdata <= trim_green_r;
                `ADDR_TRIM_IR: o_reg_rdata <= trim_ir_r;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Channel control from mode
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_analog_enable <= 1'b0;
            o_ambient_channel_run <= 1'b0;
            o_near_channel_run <= 1'b0;
            o_light_src <= lps_pkg::SRC_DIFF;
            o_light_gain_select <= 2'h0;
            o_light_compare_en <= 1'b0;
            o_near_compare_en <= 1'b0;
        end else begin
            o_analog_enable <= (mode_e != lps_pkg::MODE_SHUTDOWN);
            o_ambient_channel_run <= mode_runs_light(mode_e) && !phase_near_r;
            o_near_channel_run <= mode_runs_near(mode_e)
                && (phase_near_r || mode_e == lps_pkg::MODE_NEAR_ONLY);
            unique case (mode_e)
                lps_pkg::MODE_LIGHT_GREEN: o_light_src <= lps_pkg::SRC_GREEN;
                lps_pkg::MODE_LIGHT_IR: o_light_src <= lps_pkg::SRC_IR;
                default: o_light_src <= lps_pkg::SRC_DIFF;
            endcase
            o_light_gain_select <= rx_cfg_r[1:0];
            o_light_compare_en <= main_cfg_r[`BIT_LIGHT_EN];
            o_near_compare_en <= main_cfg_r[`BIT_NEAR_EN];
        end
    end

    // Interleave phase and conversion start
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            phase_near_r <= 1'b0;
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= mode_runs_light(mode_e) && !phase_near_r && !conv_busy
                && !conv_start_r;
            if (mode_e != lps_pkg::MODE_INTERLEAVE) begin
                phase_near_r <= 1'b0;
            end else if (!phase_near_r && conv_done) begin
                phase_near_r <= 1'b1;
            end else if (phase_near_r && i_near_done) begin
                phase_near_r <= 1'b0;
            end
        end
    end

    lps_conv_timer #(
        .CLK_HZ(CLK_HZ)
    ) u_conv_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(conv_start_r),
        .i_time_sel(rx_cfg_r[3:2]),
        .o_busy(conv_busy),
        .o_done(conv_done),
        .o_bits(conv_bits)
    );

    // Results
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_light_result <= 14'h0000;
            o_light_bits <= 4'hE;
        end else if (i_light_done && mode_runs_light(mode_e)) begin
            o_light_bits <= conv_bits;
            unique case (mode_e)
                lps_pkg::MODE_LIGHT_GREEN: o_light_result <= i_green_data;
                lps_pkg::MODE_LIGHT_IR: o_light_result <= i_ir_data;
                default: o_light_result <= (i_green_data > i_ir_data)
                    ? 14'(i_green_data - i_ir_data) : 14'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_near_result <= 8'h00;
        end else if (i_near_done && mode_runs_near(mode_e)) begin
            o_near_result <= i_near_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_green_fine_gain <= 8'h00;
            o_infrared_fine_gain <= 8'h00;
        end else if (main_cfg_r[`BIT_GAIN_SRC]) begin
            o_green_fine_gain <= i_factory_green_gain;
            o_infrared_fine_gain <= i_factory_ir_gain;
        end else begin
            o_green_fine_gain <= trim_green_r;
            o_infrared_fine_gain <= trim_ir_r;
        end
    end
endmodule

//--- lps_cfg.svh
// Constants for the light/proximity control and status register block
// Assumes a 25 MHz core clock and byte-wide register access by address
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

`define ADDR_IRQ_STATUS 8'h00
`define ADDR_MAIN_CFG 8'h01
`define ADDR_RX_CFG 8'h02
`define ADDR_TRIM_GREEN 8'h0F
`define ADDR_TRIM_IR 8'h10

`define MAIN_CFG_RESET 8'h24
`define RX_CFG_RESET 8'h00
`define TRIM_RESET 8'h80
`define STATUS_RESET 8'h04
`define RX_CFG_FIXED 8'hF0

`define BIT_POWER_UP 2
`define BIT_NEAR_FLAG 1
`define BIT_LIGHT_FLAG 0
`define BIT_GAIN_SRC 5
`define BIT_NEAR_EN 1
`define BIT_LIGHT_EN 0
`define MODE_MSB 4
`define MODE_LSB 2

`define CLK_HZ 25000000
// Integration times, in microseconds (_US) or nanoseconds (_NS)
`define TINT_00_US 100000
`define TINT_01_US 25000
`define TINT_10_NS 6250000
`define TINT_11_NS 1562500

`endif

//--- lps_pkg.sv
// Types shared by the light/proximity register block
// Assumes no other package
package lps_pkg;
    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'h0,
        MODE_LIGHT_DIFF = 3'h1,
        MODE_LIGHT_GREEN = 3'h2,
        MODE_LIGHT_IR = 3'h3,
        MODE_INTERLEAVE = 3'h4,
        MODE_NEAR_ONLY = 3'h5,
        MODE_RSVD6 = 3'h6,
        MODE_RSVD7 = 3'h7
    } op_mode_t;

    typedef enum logic [1:0] {
        SRC_DIFF = 2'h0,
        SRC_GREEN = 2'h1,
        SRC_IR = 2'h2
    } light_src_t;
endpackage

//--- lps_conv_timer.sv
// Integration timer for the ambient converter
// Assumes a 25 MHz clock; i_start is a one-cycle pulse
`timescale 1ns/100ps
`include "lps_cfg.svh"
module lps_conv_timer #(
    parameter int unsigned CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Control
    input wire logic i_start,
    input wire logic [1:0] i_time_sel,
    // Status
    output logic o_busy,
    output logic o_done,
    output logic [3:0] o_bits
);
    localparam longint unsigned CYC_00 = longint'(`TINT_00_US) * CLK_HZ / 1000000;
    localparam longint unsigned CYC_01 = longint'(`TINT_01_US) * CLK_HZ / 1000000;
    localparam longint unsigned CYC_10 = longint'(`TINT_10_NS) * CLK_HZ / 1000000000;
    localparam longint unsigned CYC_11 = longint'(`TINT_11_NS) * CLK_HZ / 1000000000;

    // Shortest period must be a cycle, longest must fit the counter
    if (CYC_11 < 1 || CYC_00 >= (64'h1 << 24)) begin : gen_clk_range
        $error("lps_conv_timer: CLK_HZ out of range");
    end

    logic [23:0] cnt_r;

    function automatic logic [23:0] period_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: period_of = 24'(CYC_00);
            2'h1: period_of = 24'(CYC_01);
            2'h2: period_of = 24'(CYC_10);
            default: period_of = 24'(CYC_11);
        endcase
    endfunction

    // Resolution grows with integration time
    function automatic logic [3:0] bits_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: bits_of = 4'hE;
            2'h1: bits_of = 4'hC;
            2'h2: bits_of = 4'hA;
            default: bits_of = 4'h8;
        endcase
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_r <= 24'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_bits <= 4'hE;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                cnt_r <= period_of(i_time_sel) - 24'h1;
                o_bits <= bits_of(i_time_sel);
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (cnt_r == 24'h0) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 24'h1;
                end
            end
        end
    end
endmodule

//--- host_model.sv
// Host side of the byte register port, standing in for the I2C master
// Assumes the register block samples requests on the rising clock edge
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic i_clk,
    // Register port
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= (a == 8'h01 && d[4:3] == 2'b11) ? (d & 8'hEF) : d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(negedge i_clk);
        d = i_rdata;
    endtask
endmodule

//--- lps_regs_monitor.sv
// Port checker for the light/proximity register block
// Assumes binding onto lps_regs; single clock, sync active-low reset
`timescale 1ns/100ps
module lps_regs_monitor #(
    parameter bit FIRST_REVISION = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_light_event,
    input wire logic i_near_event,
    input wire logic [7:0] i_factory_green_gain,
    input wire logic [7:0] o_green_fine_gain,
    input wire logic o_analog_enable,
    input wire logic [1:0] o_light_gain_select,
    input wire logic o_light_compare_en,
    input wire logic o_near_compare_en,
    input wire logic o_threshold_reset,
    input wire logic o_int_out,
    input wire logic o_int_oen
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic rd_st;
    logic wr_main;
    logic no_ev;
    assign rd_st = i_reg_rd && i_reg_addr == 8'h00;
    assign wr_main = i_reg_wr && i_reg_addr == 8'h01;
    assign no_ev = !i_light_event && !i_near_event;
    thr_reset_a: assert property ($rose(i_rstn) |-> o_threshold_reset)
        else $error("threshold reset not held after release");
    pwr_pin_a: assert property ($rose(i_rstn) && !FIRST_REVISION |=> !o_int_oen)
        else $error("power-up flag did not pull pin");
    stat_clear_a: assert property (rd_st && no_ev ##1 no_ev |=> o_int_oen)
        else $error("status read did not release pin");
    light_irq_a: assert property (i_light_event && o_light_compare_en && !wr_main && !$past(wr_main)
        |-> ##2 !o_int_oen)
        else $error("light event did not pull pin");
    near_irq_a: assert property (i_near_event && o_near_compare_en && !wr_main && !$past(wr_main)
        |-> ##2 !o_int_oen)
        else $error("near event did not pull pin");
    rx_fixed_a: assert property (i_reg_rd && i_reg_addr == 8'h02 |=> o_reg_rdata[7:4] == 4'hF)
        else $error("receive config upper bits not one");
    rx_gain_a: assert property (i_reg_wr && i_reg_addr == 8'h02 ##1 !i_reg_wr[*2]
        |-> o_light_gain_select == $past(i_reg_wdata[1:0], 2))
        else $error("gain select not following write");
    gain_src_a: assert property (wr_main && i_reg_wdata[5] ##1 !i_reg_wr[*2]
        |-> o_green_fine_gain == i_factory_green_gain)
        else $error("factory gain not selected");
    mode_off_a: assert property (wr_main ##1 !i_reg_wr[*2]
        |-> o_analog_enable == ($past(i_reg_wdata[4:2], 2) != 3'h0))
        else $error("analog enable wrong for mode");
    pin_low_a: assert property (o_int_out == 1'b0)
        else $error("interrupt pin driven high");
    cover property (i_light_event && o_light_compare_en);
    cover property (rd_st && !o_int_oen);
    cover property ($fell(o_int_oen));
endmodule
bind lps_regs lps_regs_monitor #(.FIRST_REVISION(FIRST_REVISION)) lps_regs_monitor_i (.*);

//--- lps_regs_tb.sv
// Self-checking bench for the light/proximity register block
// Assumes host_model drives the register port; events driven here
`timescale 1ns/100ps
module lps_regs_tb;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic wr, rd, lev = 1'b0, nev = 1'b0, ldone = 1'b0, ndone = 1'b0;
    logic [7:0] addr, wdata, rdata, d, nd = 8'h00, exp_n, ggain, igain, nres;
    logic [13:0] g = 14'h0000, ir = 14'h0000, gv, exp_l, lres;
    logic aen, arun, nrun, lce, nce, tres, io, ioen;
    logic [1:0] src, gsel;
    logic [3:0] lbits;
    int err_total = 0;
    int checked = 0;
    always #20 i_clk = ~i_clk;
    host_model host_model_i (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata), .i_rdata(rdata));
    // Slow clock figure shortens the integration counts to between 10 and 640 cycles
    lps_regs #(.CLK_HZ(32'h1900)) lps_regs_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_light_event(lev),
        .i_near_event(nev), .i_light_done(ldone), .i_green_data(g), .i_ir_data(ir),
        .i_near_done(ndone), .i_near_data(nd), .i_factory_green_gain(8'h5A),
        .i_factory_ir_gain(8'hA5), .o_green_fine_gain(ggain), .o_infrared_fine_gain(igain),
        .o_analog_enable(aen), .o_ambient_channel_run(arun), .o_near_channel_run(nrun),
        .o_light_src(src), .o_light_gain_select(gsel), .o_light_compare_en(lce),
        .o_near_compare_en(nce), .o_threshold_reset(tres), .o_light_result(lres),
        .o_light_bits(lbits), .o_near_result(nres), .o_int_out(io), .o_int_oen(ioen));
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] s);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host_model_i.rd(a, d);
        chk("rdata", 14'(e), 14'(d));
    endtask
    task automatic settle;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task automatic pulse_ev(input logic l);
        @(posedge i_clk);
        lev <= l;
        nev <= !l;
        @(posedge i_clk);
        lev <= 1'b0;
        nev <= 1'b0;
        settle;
    endtask
    task automatic conv(input logic [13:0] gi, input logic [13:0] ii, input logic [7:0] ni);
        @(posedge i_clk);
        {ldone, ndone, g, ir, nd} <= {2'b11, gi, ii, ni};
        @(posedge i_clk);
        {ldone, ndone} <= 2'b00;
        settle;
    endtask
    task automatic do_reset;
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk("thr_reset", 14'h1, 14'(tres));
        @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        do_reset;
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        chk("int_oen", 14'h0, 14'(ioen));
        rdc(8'h00, 8'h04);
        settle;
        chk("int_oen", 14'h1, 14'(ioen));
        rdc(8'h00, 8'h00);
        rdc(8'h01, 8'h24);
        rdc(8'h02, 8'hF0);
        rdc(8'h0F, 8'h80);
        rdc(8'h10, 8'h80);
        rdc(8'h05, 8'h00);
        host_model_i.wr(8'h00, 8'hFF);
        rdc(8'h00, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            host_model_i.wr(8'h02, {4'h0, 2'(i), 2'(3 - i)});
            // Let the running conversion end and one start with the new time
            repeat (700) @(posedge i_clk);
            conv(14'h0000, 14'h0000, 8'h00);
            rdc(8'h02, {4'hF, 2'(i), 2'(3 - i)});
            chk("bits", 14'(14 - 2 * i), 14'(lbits));
            chk("gsel", 14'(3 - i), 14'(gsel));
        end
        host_model_i.wr(8'h02, 8'h00);
        $display("test receive config done");
        host_model_i.wr(8'h0F, 8'h11);
        host_model_i.wr(8'h10, 8'h22);
        host_model_i.wr(8'h01, 8'h24);
        settle;
        chk("ggain", 14'h5A, 14'(ggain));
        chk("igain", 14'hA5, 14'(igain));
        host_model_i.wr(8'h01, 8'h04);
        settle;
        chk("ggain", 14'h11, 14'(ggain));
        chk("igain", 14'h22, 14'(igain));
        $display("test gain source done");
        exp_l = 14'h0000;
        exp_n = 8'h00;
        for (int m = 0; m < 6; m++) begin
            host_model_i.wr(8'h01, {3'b000, 3'(m), 2'b00});
            settle;
            chk("aen", 14'(m != 0), 14'(aen));
            if (m != 4) chk("arun", 14'(m > 0 && m < 4), 14'(arun));
            if (m != 4) chk("nrun", 14'(m == 5), 14'(nrun));
            if (m == 4) chk("run_alt", 14'h1, 14'(arun ^ nrun));
            if (m > 0 && m < 4) chk("src", 14'(m - 1), 14'(src));
            gv = 14'h0100 + 14'(m * 16);
            conv(gv, 14'h0020, 8'h30 + 8'(m));
            if (m > 0 && m < 5) exp_l = (m == 2) ? gv : (m == 3) ? 14'h0020 : gv - 14'h0020;
            if (m > 3) exp_n = 8'h30 + 8'(m);
            chk("lres", exp_l, lres);
            chk("nres", 14'(exp_n), 14'(nres));
        end
        $display("test modes done");
        host_model_i.wr(8'h01, 8'h07);
        for (int k = 0; k < 2; k++) begin
            pulse_ev(k == 0);
            chk("int_oen", 14'h0, 14'(ioen));
            chk("int_out", 14'h0, 14'(io));
            chk("cmp_en", 14'h3, 14'({nce, lce}));
            rdc(8'h00, (k == 0) ? 8'h01 : 8'h02);
            settle;
            chk("int_oen", 14'h1, 14'(ioen));
        end
        host_model_i.wr(8'h01, 8'h04);
        pulse_ev(1'b1);
        pulse_ev(1'b0);
        chk("int_oen", 14'h1, 14'(ioen));
        chk("cmp_en", 14'h0, 14'({nce, lce}));
        rdc(8'h00, 8'h00);
        host_model_i.wr(8'h01, 8'h07);
        pulse_ev(1'b1);
        host_model_i.wr(8'h01, 8'h06);
        settle;
        chk("int_oen", 14'h1, 14'(ioen));
        rdc(8'h00, 8'h00);
        $display("test interrupts done");
        host_model_i.wr(8'h02, 8'h0A);
        do_reset;
        rdc(8'h01, 8'h24);
        rdc(8'h02, 8'hF0);
        rdc(8'h00, 8'h04);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule
